// ===== logic/lmb_params.svh
`ifndef LMB_PARAMS_SVH
`define LMB_PARAMS_SVH

// Size of one message buffer in bytes.
`define LMB_BUF_BYTES 7'h60
// Number of HDLC controllers that can own the buffers.
`define LMB_CTRL_COUNT 3
// Register indices; the byte address on the bus is four times the index.
`define LMB_IDX_SEL 16'h011B
`define LMB_IDX_TXCNT1 16'h0114
`define LMB_IDX_TXCNT2 16'h0144
`define LMB_IDX_TXCNT3 16'h0154
`define LMB_IDX_RXCNT1 16'h0115
`define LMB_IDX_RXCNT2 16'h0145
`define LMB_IDX_RXCNT3 16'h0155
`define LMB_IDX_BUF0 16'h0600
`define LMB_IDX_BUF1 16'h0700
`define LMB_IDX_ISTAT 16'h0120
`define LMB_IDX_IMASK 16'h0121
// Reset values.
`define LMB_RST_SEL 2'h0
`define LMB_RST_BYTE 8'h00
`define LMB_RST_IDX 7'h00
`define LMB_RST_IRQ 3'h0
// Interrupt status bit positions.
`define LMB_IRQ_RX_END_OF_TRANSFER_IRQ 0
`define LMB_IRQ_TXDONE 1
`define LMB_IRQ_RXOVF 2

`endif

// ===== logic/lmb_pkg.sv
`include "lmb_params.svh"

package lmb_pkg;
  typedef logic [7:0] lmb_byte_t;
  typedef logic [6:0] lmb_idx_t;
  typedef logic [15:0] lmb_reg_idx_t;
  typedef logic [2:0] lmb_irq_t;
  typedef enum logic {
    LMB_TX_IDLE = 1'b0,
    LMB_TX_SEND = 1'b1
  } lmb_tx_state_t;
endpackage : lmb_pkg

// ===== logic/lmb_byte_store.sv
`include "lmb_params.svh"

module lmb_byte_store (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic wrEn,
  input wire lmb_pkg::lmb_idx_t wrIdx,
  input wire lmb_pkg::lmb_byte_t wrData,
  input wire lmb_pkg::lmb_idx_t rdIdx,
  output lmb_pkg::lmb_byte_t rdData
);
  import lmb_pkg::*;

  lmb_byte_t mem [`LMB_BUF_BYTES];

  // One flip-flop byte per entry, written when its index is addressed.
  genvar e;
  generate
    for (e = 0; e < `LMB_BUF_BYTES; e++) begin : g_entry
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          mem[e] <= `LMB_RST_BYTE;
        end else if (wrEn && wrIdx == lmb_idx_t'(e)) begin
          mem[e] <= wrData;
        end
      end
    end
  endgenerate

  // Reads past the end of the buffer return zero.
  assign rdData = (rdIdx < `LMB_BUF_BYTES) ? mem[rdIdx] : `LMB_RST_BYTE;
endmodule : lmb_byte_store

// ===== logic/lmb_access.sv
// Notes on behaviour
// - Second 96-byte buffer behind one auto-incrementing location.
// - Select register picks controller; accesses routed there.
// - Bytes in free second buffer go out framed.
// - Sent transmit bytes are not readable back.
// - Receive pointer flag names buffer holding message.
// - Reads of second buffer return received message.
// - Buffer accesses advance the byte index up to 96; writes to a busy transmit buffer do not.
// - First buffer has its own auto-incrementing location.
`include "lmb_params.svh"

module lmb_access (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [1:0] hdlcSel,
  output lmb_pkg::lmb_byte_t txData,
  output logic txValid,
  output logic txLast,
  input wire logic txReady,
  input wire lmb_pkg::lmb_byte_t rxData,
  input wire logic rxValid,
  input wire logic rxLast,
  output logic irq
);
  import lmb_pkg::*;
  localparam lmb_reg_idx_t TX_CNT_IDX [`LMB_CTRL_COUNT] = '{`LMB_IDX_TXCNT1, `LMB_IDX_TXCNT2, `LMB_IDX_TXCNT3};
  localparam lmb_reg_idx_t RX_CNT_IDX [`LMB_CTRL_COUNT] = '{`LMB_IDX_RXCNT1, `LMB_IDX_RXCNT2, `LMB_IDX_RXCNT3};
  localparam lmb_reg_idx_t BUF_IDX [2] = '{`LMB_IDX_BUF0, `LMB_IDX_BUF1};
  // Bus state.
  logic wrPend, next_wrPend, rdPend, next_rdPend, next_hreadyout;
  lmb_reg_idx_t busAddr, next_busAddr;
  logic [31:0] next_hrdata;
  // Register state.
  logic [1:0] sel, next_sel;
  lmb_idx_t txCnt [`LMB_CTRL_COUNT], next_txCnt [`LMB_CTRL_COUNT];
  lmb_irq_t irqStatus, next_irqStatus, irqMask, next_irqMask, irqEv;
  // Transmit state.
  lmb_tx_state_t txState, next_txState;
  logic [1:0] txBusy, next_txBusy;
  logic txNext, next_txNext, txSendBuf, next_txSendBuf;
  lmb_idx_t txLen [2], next_txLen [2];
  lmb_idx_t txWrIdx [2], next_txWrIdx [2];
  lmb_idx_t txSendIdx, next_txSendIdx;
  lmb_byte_t next_txData;
  logic next_txValid, next_txLast, txDoneEv, txLaunch;
  lmb_idx_t txLaunchLen;
  // Receive state.
  logic rxFillBuf, next_rxFillBuf, rxPtr, next_rxPtr, rxEotEv, rxOvfEv;
  lmb_idx_t rxFillIdx, next_rxFillIdx, rxLen, next_rxLen;
  lmb_idx_t rxRdIdx [2], next_rxRdIdx [2];
  // Store ports.
  lmb_byte_t txRd [2], rxRd [2];
  logic [1:0] txStoreWr, rxStoreWr;
  logic addrTaken, wrDo;
  // An address phase counts only while the bus is ready; write data follows one cycle later.
  assign addrTaken = hsel && htrans[1] && hready;
  assign wrDo = wrPend && hready;
  // Two stores per buffer: a transmit side written by software and a receive side read by software.
  for (genvar b = 0; b < 2; b++) begin : g_buf
    assign txStoreWr[b] = wrDo && busAddr == BUF_IDX[b] && !txBusy[b] && txWrIdx[b] < `LMB_BUF_BYTES;
    assign rxStoreWr[b] = rxValid && rxFillBuf == 1'(b) && rxFillIdx < `LMB_BUF_BYTES;
    lmb_byte_store u_tx_store (.core_clk(core_clk), .rstn(rstn), .wrEn(txStoreWr[b]), .wrIdx(txWrIdx[b]),
      .wrData(hwdata[7:0]), .rdIdx(txSendIdx), .rdData(txRd[b]));
    lmb_byte_store u_rx_store (.core_clk(core_clk), .rstn(rstn), .wrEn(rxStoreWr[b]), .wrIdx(rxFillIdx),
      .wrData(rxData), .rdIdx(rxRdIdx[b]), .rdData(rxRd[b]));
  end
  // Bus slave: writes finish without wait, reads add one wait state so that a preceding write is visible.
  always_comb begin
    next_wrPend = addrTaken && hwrite && hsize <= 3'h2;
    next_rdPend = addrTaken && !hwrite;
    next_busAddr = addrTaken ? haddr[17:2] : busAddr;
    next_hreadyout = !(addrTaken && !hwrite);
    next_hrdata = hrdata;
    if (rdPend) begin
      next_hrdata = 32'h0000_0000;
      if (busAddr == `LMB_IDX_SEL) begin
        next_hrdata[1:0] = sel;
      end else if (busAddr == `LMB_IDX_ISTAT) begin
        next_hrdata[2:0] = irqStatus;
      end else if (busAddr == `LMB_IDX_IMASK) begin
        next_hrdata[2:0] = irqMask;
      end else if (busAddr == BUF_IDX[0]) begin
        next_hrdata[7:0] = rxRd[0];
      end else if (busAddr == BUF_IDX[1]) begin
        next_hrdata[7:0] = rxRd[1];
      end else begin
        for (int k = 0; k < `LMB_CTRL_COUNT; k++) begin
          if (busAddr == TX_CNT_IDX[k]) begin
            next_hrdata[7:0] = {txNext && sel == 2'(k), txCnt[k]};
          end else if (busAddr == RX_CNT_IDX[k]) begin
            next_hrdata[7:0] = (sel == 2'(k)) ? {rxPtr, rxLen} : `LMB_RST_BYTE;
          end
        end
      end
    end
  end
  // Bus response registers; unmapped indices simply match no branch and read zero.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wrPend <= 1'b0;
      rdPend <= 1'b0;
      busAddr <= 16'h0000;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else begin
      wrPend <= next_wrPend;
      rdPend <= next_rdPend;
      busAddr <= next_busAddr;
      hreadyout <= next_hreadyout;
      hrdata <= next_hrdata;
      hresp <= 1'b0;
    end
  end
  // Control registers and the sticky interrupt status; a new event wins over a clear in the same cycle.
  always_comb begin
    next_sel = sel;
    next_txCnt = txCnt;
    next_irqMask = irqMask;
    irqEv = 3'h0;
    irqEv[`LMB_IRQ_RX_END_OF_TRANSFER_IRQ] = rxEotEv;
    irqEv[`LMB_IRQ_TXDONE] = txDoneEv;
    irqEv[`LMB_IRQ_RXOVF] = rxOvfEv;
    next_irqStatus = irqStatus | irqEv;
    if (wrDo) begin
      if (busAddr == `LMB_IDX_SEL && hwdata[1:0] < 2'(`LMB_CTRL_COUNT)) begin
        next_sel = hwdata[1:0];
      end else if (busAddr == `LMB_IDX_ISTAT) begin
        next_irqStatus = (irqStatus & ~hwdata[2:0]) | irqEv;
      end else if (busAddr == `LMB_IDX_IMASK) begin
        next_irqMask = hwdata[2:0];
      end else begin
        for (int k = 0; k < `LMB_CTRL_COUNT; k++) begin
          if (busAddr == TX_CNT_IDX[k]) begin
            next_txCnt[k] = hwdata[6:0];
          end
        end
      end
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sel <= `LMB_RST_SEL;
      hdlcSel <= `LMB_RST_SEL;
      txCnt <= '{default: `LMB_RST_IDX};
      irqStatus <= `LMB_RST_IRQ;
      irqMask <= `LMB_RST_IRQ;
      irq <= 1'b0;
    end else begin
      sel <= next_sel;
      hdlcSel <= next_sel;
      txCnt <= next_txCnt;
      irqStatus <= next_irqStatus;
      irqMask <= next_irqMask;
      irq <= |(next_irqStatus & next_irqMask);
    end
  end
  // Writing a non-zero count to the selected controller's count register hands the free buffer to the sender.
  assign txLaunchLen = (hwdata[6:0] > `LMB_BUF_BYTES) ? `LMB_BUF_BYTES : hwdata[6:0];
  assign txLaunch = wrDo && busAddr == TX_CNT_IDX[sel] && hwdata[6:0] != 7'h00 && !txBusy[txNext];
  // Transmit side: host loading, buffer alternation and the byte stream towards the framer.
  always_comb begin
    next_txBusy = txBusy;
    next_txNext = txNext;
    next_txLen = txLen;
    next_txWrIdx = txWrIdx;
    next_txState = txState;
    next_txSendBuf = txSendBuf;
    next_txSendIdx = txSendIdx;
    next_txData = txData;
    next_txValid = txValid;
    next_txLast = txLast;
    txDoneEv = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (txStoreWr[i]) begin
        next_txWrIdx[i] = txWrIdx[i] + 7'h01;
      end
    end
    if (txLaunch) begin
      next_txBusy[txNext] = 1'b1;
      next_txLen[txNext] = txLaunchLen;
      next_txWrIdx[txNext] = `LMB_RST_IDX;
      next_txNext = !txNext;
    end
    case (txState)
      LMB_TX_IDLE: begin
        if (txBusy[txSendBuf]) begin
          next_txState = LMB_TX_SEND;
          next_txSendIdx = `LMB_RST_IDX;
        end
      end
      LMB_TX_SEND: begin
        if (!txValid || txReady) begin
          if (txSendIdx < txLen[txSendBuf]) begin
            next_txValid = 1'b1;
            next_txData = txRd[txSendBuf];
            next_txLast = txSendIdx == txLen[txSendBuf] - 7'h01;
            next_txSendIdx = txSendIdx + 7'h01;
          end else begin
            next_txValid = 1'b0;
            next_txLast = 1'b0;
            next_txBusy[txSendBuf] = 1'b0;
            next_txSendBuf = !txSendBuf;
            next_txState = LMB_TX_IDLE;
            txDoneEv = 1'b1;
          end
        end
      end
      default: next_txState = LMB_TX_IDLE;
    endcase
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      txBusy <= 2'h0;
      txNext <= 1'b0;
      txLen <= '{default: `LMB_RST_IDX};
      txWrIdx <= '{default: `LMB_RST_IDX};
      txState <= LMB_TX_IDLE;
      txSendBuf <= 1'b0;
      txSendIdx <= `LMB_RST_IDX;
      txData <= `LMB_RST_BYTE;
      txValid <= 1'b0;
      txLast <= 1'b0;
    end else begin
      txBusy <= next_txBusy;
      txNext <= next_txNext;
      txLen <= next_txLen;
      txWrIdx <= next_txWrIdx;
      txState <= next_txState;
      txSendBuf <= next_txSendBuf;
      txSendIdx <= next_txSendIdx;
      txData <= next_txData;
      txValid <= next_txValid;
      txLast <= next_txLast;
    end
  end
  // Receive side: fill alternate buffers, publish the pointer at the end of a message, advance host reads.
  always_comb begin
    next_rxFillBuf = rxFillBuf;
    next_rxFillIdx = rxFillIdx;
    next_rxPtr = rxPtr;
    next_rxLen = rxLen;
    next_rxRdIdx = rxRdIdx;
    rxEotEv = 1'b0;
    rxOvfEv = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (rdPend && busAddr == BUF_IDX[i] && rxRdIdx[i] < `LMB_BUF_BYTES) begin
        next_rxRdIdx[i] = rxRdIdx[i] + 7'h01;
      end
    end
    if (rxValid) begin
      if (rxFillIdx < `LMB_BUF_BYTES) begin
        next_rxFillIdx = rxFillIdx + 7'h01;
      end else begin
        rxOvfEv = 1'b1;
      end
      if (rxLast) begin
        next_rxPtr = rxFillBuf;
        next_rxLen = (rxFillIdx < `LMB_BUF_BYTES) ? rxFillIdx + 7'h01 : `LMB_BUF_BYTES;
        next_rxRdIdx[rxFillBuf] = `LMB_RST_IDX;
        next_rxFillBuf = !rxFillBuf;
        next_rxFillIdx = `LMB_RST_IDX;
        rxEotEv = 1'b1;
      end
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rxFillBuf <= 1'b0;
      rxFillIdx <= `LMB_RST_IDX;
      rxPtr <= 1'b0;
      rxLen <= `LMB_RST_IDX;
      rxRdIdx <= '{default: `LMB_RST_IDX};
    end else begin
      rxFillBuf <= next_rxFillBuf;
      rxFillIdx <= next_rxFillIdx;
      rxPtr <= next_rxPtr;
      rxLen <= next_rxLen;
      rxRdIdx <= next_rxRdIdx;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // A read is taken, waits one cycle, then completes.
  sequence s_readTaken;
    addrTaken && !hwrite;
  endsequence
  sequence s_readWaitDone;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_readWait;
    s_readTaken |=> s_readWaitDone;
  endproperty
  a_readWait: assert property (p_readWait) else $error("read did not complete after one wait state");
  property p_selRoute;
    wrDo && busAddr == `LMB_IDX_SEL && hwdata[1:0] < 2'(`LMB_CTRL_COUNT) |=> hdlcSel == $past(hwdata[1:0]);
  endproperty
  a_selRoute: assert property (p_selRoute) else $error("controller select not routed");
  property p_freeFlagToggle;
    txLaunch |=> txNext != $past(txNext) && txBusy[$past(txNext)];
  endproperty
  a_freeFlagToggle: assert property (p_freeFlagToggle) else $error("free flag did not move on launch");
  property p_noWriteWhileBusy;
    wrDo && busAddr == BUF_IDX[1] && txBusy[1] |=> txWrIdx[1] == $past(txWrIdx[1]);
  endproperty
  a_noWriteWhileBusy: assert property (p_noWriteWhileBusy) else $error("busy buffer accepted a byte");
  property p_lastFreesBuffer;
    txValid && txReady && txLast |-> ##[1:2] !txValid;
  endproperty
  a_lastFreesBuffer: assert property (p_lastFreesBuffer) else $error("sender did not stop after last byte");
  property p_rxPointer;
    rxValid && rxLast |=> rxPtr == $past(rxFillBuf) && irqStatus[`LMB_IRQ_RX_END_OF_TRANSFER_IRQ] && rxRdIdx[rxPtr] == 7'h00;
  endproperty
  a_rxPointer: assert property (p_rxPointer) else $error("receive pointer or event not set");
  property p_readAdvance;
    rdPend && busAddr == BUF_IDX[1] && rxRdIdx[1] < `LMB_BUF_BYTES && !(rxValid && rxLast && rxFillBuf)
      |=> rxRdIdx[1] == $past(rxRdIdx[1]) + 7'h01;
  endproperty
  a_readAdvance: assert property (p_readAdvance) else $error("buffer read did not advance index");
  property p_indexCap;
    rxRdIdx[0] <= 7'h60 && rxRdIdx[1] <= 7'h60 && txWrIdx[0] <= 7'h60 && txWrIdx[1] <= 7'h60;
  endproperty
  a_indexCap: assert property (p_indexCap) else $error("byte index passed buffer size");
  property p_irqLevel;
    irq == |(irqStatus & irqMask);
  endproperty
  a_irqLevel: assert property (p_irqLevel) else $error("interrupt level wrong");
endmodule : lmb_access

// ===== testbench/lmb_access_bench.sv
`include "lmb_params.svh"

module lmb_access_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import lmb_pkg::*;

  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [1:0] hdlcSel;
  lmb_byte_t txData;
  logic txValid;
  logic txLast;
  logic txReady = 1'b0;
  lmb_byte_t rxData = 8'h00;
  logic rxValid = 1'b0;
  logic rxLast = 1'b0;
  logic irq;
  logic [31:0] rdVal;
  int mismatches = 0;
  int comparisons = 0;

  // The single slave's ready closes the loop back into its own hready.
  lmb_access i_lmb_access (
    .core_clk(core_clk),
    .rstn(rstn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hdlcSel(hdlcSel),
    .txData(txData),
    .txValid(txValid),
    .txLast(txLast),
    .txReady(txReady),
    .rxData(rxData),
    .rxValid(rxValid),
    .rxLast(rxLast),
    .irq(irq)
  );

  // Free-running 125 MHz core clock.
  always #4 core_clk = ~core_clk;

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  // Compares with case equality so an unknown never passes.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      mismatches++;
    end
  endtask : check

  // Waits for the edge at which hready is sampled high, bounded.
  task automatic waitReady();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (n >= 64) begin
      mismatches++;
      summarize();
    end
  endtask : waitReady

  // One single-word transfer; entered and left just after a rising edge.
  task automatic busAccess(input logic wr, input logic [15:0] idx, input lmb_byte_t data);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    haddr <= {14'h0000, idx, 2'h0};
    waitReady();
    htrans <= 2'h0;
    hwdata <= {24'h000000, data};
    waitReady();
    rdVal = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask : busAccess

  task automatic wr(input logic [15:0] idx, input lmb_byte_t data);
    busAccess(1'b1, idx, data);
  endtask : wr

  task automatic rd(input logic [15:0] idx, input lmb_byte_t exp);
    busAccess(1'b0, idx, 8'h00);
    check(rdVal, {24'h000000, exp});
  endtask : rd

  // Takes one transmit byte, stalling a cycle before each acceptance.
  task automatic takeTx(input lmb_byte_t exp, input logic expLast);
    int n;
    logic hit;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      hit = (txValid === 1'b1) && (txReady === 1'b1);
      txReady <= !txReady && !hit;
    end while (!hit && n < 64);
    if (!hit) begin
      mismatches++;
      summarize();
    end
    check({24'h000000, txData}, {24'h000000, exp});
    check({31'h0, txLast}, {31'h0, expLast});
  endtask : takeTx

  // Sends one received message of len bytes counting up from base.
  task automatic sendRx(input int len, input lmb_byte_t base);
    for (int i = 0; i < len; i++) begin
      rxValid <= 1'b1;
      rxData <= lmb_byte_t'(base + i);
      rxLast <= (i == len - 1);
      @(posedge core_clk);
    end
    rxValid <= 1'b0;
    rxLast <= 1'b0;
    @(posedge core_clk);
  endtask : sendRx

  // Main sequence: reset, selection, transmit, receive and interrupts.
  initial begin
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    check({31'h0, irq}, 32'h0);
    rd(`LMB_IDX_BUF1, 8'h00);
    rd(16'h0200, 8'h00);
    wr(`LMB_IDX_SEL, 8'h02);
    @(posedge core_clk); // The select flop updates at the write's own edge.
    check({30'h0, hdlcSel}, 32'h2);
    wr(`LMB_IDX_SEL, 8'h03);
    @(posedge core_clk); // A refused write must leave the select unchanged.
    check({30'h0, hdlcSel}, 32'h2);
    rd(`LMB_IDX_TXCNT3, 8'h00);
    rd(`LMB_IDX_TXCNT1, 8'h00);
    $display("test select done");
    for (int i = 0; i < 3; i++) begin
      wr(`LMB_IDX_BUF0, lmb_byte_t'(8'hA0 + i));
    end
    wr(`LMB_IDX_TXCNT3, 8'h03);
    rd(`LMB_IDX_TXCNT3, 8'h83);
    for (int i = 0; i < 4; i++) begin
      wr(`LMB_IDX_BUF1, lmb_byte_t'(8'hB0 + i));
    end
    wr(`LMB_IDX_TXCNT3, 8'h04);
    wr(`LMB_IDX_BUF1, 8'hEE);
    wr(`LMB_IDX_TXCNT3, 8'h05);
    rd(`LMB_IDX_TXCNT3, 8'h05);
    check({30'h0, hdlcSel}, 32'h2);
    for (int i = 0; i < 3; i++) begin
      takeTx(lmb_byte_t'(8'hA0 + i), i == 2);
    end
    for (int i = 0; i < 4; i++) begin
      takeTx(lmb_byte_t'(8'hB0 + i), i == 3);
    end
    rd(`LMB_IDX_BUF1, 8'h00);
    wr(`LMB_IDX_IMASK, 8'h02);
    rd(`LMB_IDX_ISTAT, 8'h02);
    check({31'h0, irq}, 32'h1);
    wr(`LMB_IDX_ISTAT, 8'h02);
    rd(`LMB_IDX_ISTAT, 8'h00);
    check({31'h0, irq}, 32'h0);
    $display("test transmit done");
    wr(`LMB_IDX_IMASK, 8'h01);
    sendRx(2, 8'h10);
    rd(`LMB_IDX_RXCNT3, 8'h02);
    check({31'h0, irq}, 32'h1);
    rd(`LMB_IDX_BUF0, 8'h10);
    rd(`LMB_IDX_BUF0, 8'h11);
    wr(`LMB_IDX_ISTAT, 8'h01);
    sendRx(96, 8'h40);
    rd(`LMB_IDX_RXCNT3, 8'hE0);
    rd(`LMB_IDX_RXCNT2, 8'h00);
    for (int i = 0; i < 96; i++) begin
      rd(`LMB_IDX_BUF1, lmb_byte_t'(8'h40 + i));
    end
    rd(`LMB_IDX_BUF1, 8'h00);
    sendRx(97, 8'h20);
    rd(`LMB_IDX_ISTAT, 8'h05);
    rd(`LMB_IDX_BUF0, 8'h20);
    $display("test receive done");
    summarize();
  end
endmodule : lmb_access_bench
